//--- hw/host_sts_pkg.sv
// Purpose: Shared constants and carriers for the host status / frame timer block
// Assumes: 16-bit register port, 200 MHz core clock
// Notes:   One instance serves one host engine; engine 1 owns the OTG bits
package host_sts_pkg;

  // ****************************************************
  // Register addresses
  // ****************************************************
  localparam logic [15:0] HOST1_EVENT_FLAGS_A      = 16'hc090;
  localparam logic [15:0] HOST1_FRAME_RELOAD_A     = 16'hc092;
  localparam logic [15:0] HOST1_FRAME_COUNTDOWN_A  = 16'hc094;
  localparam logic [15:0] HOST1_NEXT_FRAME_A       = 16'hc096;
  localparam logic [15:0] HOST1_EVENT_MASK_A       = 16'hc08c;
  localparam logic [15:0] HOST2_EVENT_FLAGS_A      = 16'hc0b0;
  localparam logic [15:0] HOST2_FRAME_RELOAD_A     = 16'hc0b2;
  localparam logic [15:0] HOST2_FRAME_COUNTDOWN_A  = 16'hc0b4;
  localparam logic [15:0] HOST2_NEXT_FRAME_A       = 16'hc0b6;
  localparam logic [15:0] HOST2_EVENT_MASK_A       = 16'hc0ac;

  // ****************************************************
  // Bit positions in flags and mask
  // ****************************************************
  localparam int BIT_SUPPLY  = 15;
  localparam int BIT_ID      = 14;
  localparam int BIT_FRAME   = 9;
  localparam int BIT_WAKE    = 6;
  localparam int BIT_CONN    = 4;
  localparam int BIT_SE0     = 2;
  localparam int BIT_DONE    = 0;

  // Writable bits of the mask and flag registers per engine
  localparam logic [15:0] EV_MASK_HOST1 = 16'hc251;
  localparam logic [15:0] EV_MASK_HOST2 = 16'h0251;

  // ****************************************************
  // Frame timer
  // ****************************************************
  localparam int          FRAME_W       = 14;
  localparam logic [13:0] RELOAD_RST    = 14'h2ee0;
  localparam int          FRAME_NUM_W   = 11;
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          TICK_HZ       = 12_000_000;
  // 200/12 is not whole: use a fractional accumulator, step 3 of 50
  localparam int          ACC_STEP      = TICK_HZ / 4_000_000;
  localparam int          ACC_MOD       = CLK_HZ / 4_000_000;
  localparam int          ACC_W         = 6;

  // Register port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  // Bus-side event strobes
  typedef struct packed {
    logic done;
    logic wake;
    logic sof_sent;
  } bus_evt_s;

endpackage

//--- hw/usb_host_status_frame_timer.sv
// Purpose: Host event flags, interrupt enables and frame timer for one host engine
// Assumes: Synchronous inputs; register port gives one-cycle rd/wr strobes
// Notes:   Read data is registered, valid one cycle after the rd strobe
`timescale 1ns/1ps

module usb_host_status_frame_timer #(
  parameter bit          HOST1       = 1'b1,                    // Engine 1 has the OTG port
  parameter logic [13:0] FIRST_COUNT = host_sts_pkg::RELOAD_RST // Counter start out of reset
) (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  srst_i,
  // Register port
  input  wire host_sts_pkg::reg_req_s req_i,
  output logic [15:0]                rdata_o,
  output logic                       rvalid_o,
  // Bus side
  input  wire host_sts_pkg::bus_evt_s evt_i,
  input  wire logic                  line_se0_i,
  input  wire logic                  supply_valid_i,
  input  wire logic                  otg_id_i,
  // Processor side
  output logic                       irq_o,
  output logic                       frame_expired_o
);
  import host_sts_pkg::*;

  // ****************************************************
  // Decode
  // ****************************************************
  localparam logic [15:0] EV_MASK = HOST1 ? EV_MASK_HOST1 : EV_MASK_HOST2;
  localparam logic [15:0] A_FLAGS = HOST1 ? HOST1_EVENT_FLAGS_A : HOST2_EVENT_FLAGS_A;
  localparam logic [15:0] A_RELD  = HOST1 ? HOST1_FRAME_RELOAD_A : HOST2_FRAME_RELOAD_A;
  localparam logic [15:0] A_CNT   = HOST1 ? HOST1_FRAME_COUNTDOWN_A : HOST2_FRAME_COUNTDOWN_A;
  localparam logic [15:0] A_FNUM  = HOST1 ? HOST1_NEXT_FRAME_A : HOST2_NEXT_FRAME_A;
  localparam logic [15:0] A_MASK  = HOST1 ? HOST1_EVENT_MASK_A : HOST2_EVENT_MASK_A;

  // Write strobe for one address
  function automatic logic wr_hit(input reg_req_s r, input logic [15:0] a);
    return r.wr && (r.addr == a);
  endfunction

  logic                   wr_flags;     // Clear write to flags
  logic                   wr_reld;      // Reload write
  logic                   wr_mask;      // Enable write
  assign wr_flags = wr_hit(req_i, A_FLAGS);
  assign wr_reld  = wr_hit(req_i, A_RELD);
  assign wr_mask  = wr_hit(req_i, A_MASK);

  // ****************************************************
  // Registers
  // ****************************************************
  logic [15:0]            flags_q;      // Sticky event flags
  logic [15:0]            flags_d;
  logic [15:0]            mask_q;       // Interrupt enables
  logic [FRAME_W-1:0]     reload_q;     // Programmed frame length
  logic [FRAME_W-1:0]     count_q;      // Live down counter
  logic [FRAME_NUM_W-1:0] fnum_q;       // Next frame number
  logic [ACC_W-1:0]       acc_q;        // Fractional tick accumulator
  logic                   tick;         // 12 MHz enable
  logic                   expire;       // Counter already at zero on a tick
  logic                   se0_q;        // Previous SE0 level
  logic                   sup_q;        // Previous supply level
  logic                   id_q;         // Previous ID level
  logic [15:0]            set_vec;      // Event set vector

  // ****************************************************
  // Timebase
  // ****************************************************
  // Fractional divider keeps the long-run average exactly 12 MHz
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      acc_q <= '0;
    end else if (acc_q + ACC_W'(ACC_STEP) >= ACC_W'(ACC_MOD)) begin
      acc_q <= acc_q + ACC_W'(ACC_STEP) - ACC_W'(ACC_MOD);
    end else begin
      acc_q <= acc_q + ACC_W'(ACC_STEP);
    end
  end
  assign tick   = (acc_q + ACC_W'(ACC_STEP) >= ACC_W'(ACC_MOD));
  assign expire = tick && (count_q == '0);

  // ****************************************************
  // Frame counter and reload
  // ****************************************************
  // Reload register, software owned
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reload_q <= RELOAD_RST;
    end else if (wr_reld) begin
      reload_q <= req_i.wdata[FRAME_W-1:0];
    end
  end

  // Down counter, refilled from reload at zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      count_q <= FIRST_COUNT;
    end else if (expire) begin
      count_q <= reload_q;
    end else if (tick) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Next frame number
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fnum_q <= '0;
    end else if (wr_reld) begin
      fnum_q <= '0;
    end else if (evt_i.sof_sent) begin
      fnum_q <= fnum_q + 1'b1;
    end
  end

  // ****************************************************
  // Event detection
  // ****************************************************
  // Previous levels for edge detection
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      se0_q <= 1'b0;
      sup_q <= 1'b0;
      id_q  <= 1'b0;
    end else begin
      se0_q <= line_se0_i;
      sup_q <= supply_valid_i;
      id_q  <= otg_id_i;
    end
  end

  // Inputs high at reset release read as edges against the zero reset values
  always_comb begin
    set_vec            = '0;
    set_vec[BIT_SUPPLY] = sup_q != supply_valid_i;
    set_vec[BIT_ID]    = id_q != otg_id_i;
    set_vec[BIT_FRAME] = expire;
    set_vec[BIT_WAKE]  = evt_i.wake;
    set_vec[BIT_CONN]  = se0_q != line_se0_i;
    set_vec[BIT_DONE]  = evt_i.done;
    set_vec            = set_vec & EV_MASK;
  end

  // Set wins over a same-cycle clear
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = flags_q & ~req_i.wdata;
    end
    flags_d = (flags_d | set_vec) & EV_MASK;
  end

  // Sticky flags
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Enable register; reserved bits held at zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= req_i.wdata & EV_MASK;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Interrupt request from flag and enable
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_d & mask_q);
    end
  end

  // Frame timer pulse for the transaction sequencer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      frame_expired_o <= 1'b0;
    end else begin
      frame_expired_o <= expire;
    end
  end

  // Registered read port; unmapped reads give zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      rdata_o  <= '0;
      if (req_i.rd) begin
        case (req_i.addr)
          A_FLAGS: rdata_o <= flags_q | (16'(line_se0_i) << BIT_SE0);
          A_RELD:  rdata_o <= 16'(reload_q);
          A_CNT:   rdata_o <= 16'(count_q);
          A_FNUM:  rdata_o <= 16'(fnum_q);
          A_MASK:  rdata_o <= mask_q;
          default: rdata_o <= '0;
        endcase
      end
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  a_frame_flag_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    expire |=> flags_q[BIT_FRAME]) else $error("frame flag not set on expiry");

  a_reload_copy: assert property (@(posedge mclk_i) disable iff (srst_i)
    expire |=> count_q == $past(reload_q)) else $error("counter not reloaded");

  a_count_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !tick |=> count_q == $past(count_q)) else $error("counter moved without tick");

  a_fnum_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_reld |=> fnum_q == '0) else $error("frame number not cleared");

  a_conn_edge: assert property (@(posedge mclk_i) disable iff (srst_i)
    $changed(line_se0_i) |=> flags_q[BIT_CONN]) else $error("connect change missed");

  a_clear_w1c: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_flags && req_i.wdata[BIT_DONE] && !evt_i.done) |=> !flags_q[BIT_DONE])
    else $error("done flag not cleared");

  a_irq_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    irq_o == $past(|(flags_d & mask_q))) else $error("interrupt mismatch");

  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    (flags_q & ~EV_MASK) == '0) else $error("reserved flag set");

  a_fnum_step: assert property (@(posedge mclk_i) disable iff (srst_i)
    (evt_i.sof_sent && !wr_reld) |=> fnum_q == $past(fnum_q) + 1'b1)
    else $error("frame number did not advance");

  // ****************************************************
  // Sequences for the multi-step checks
  // ****************************************************
  // Counter at zero on a timebase tick
  sequence s_expiry;
    tick && (count_q == '0);
  endsequence

  // Expiry pulse stands exactly one cycle
  sequence s_expiry_pulse;
    frame_expired_o ##1 !frame_expired_o;
  endsequence

  // Read of the flag register
  sequence s_flags_read;
    req_i.rd && (req_i.addr == A_FLAGS);
  endsequence

  // Read of the reload register with no write beside it
  sequence s_reload_read;
    req_i.rd && (req_i.addr == A_RELD) && !wr_reld;
  endsequence

  // ****************************************************
  // Further checks
  // ****************************************************
  // Sequencer sees one pulse per expiry
  a_expiry_pulse: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_expiry |=> s_expiry_pulse) else $error("expiry pulse malformed");

  // No pulse without an expiry behind it
  a_pulse_cause: assert property (@(posedge mclk_i) disable iff (srst_i)
    frame_expired_o |-> $past(expire)) else $error("spurious expiry pulse");

  // Enabled frame flag keeps the request up
  a_frame_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
    (flags_q[BIT_FRAME] && mask_q[BIT_FRAME] && !wr_flags) |=> irq_o) else $error("frame irq missing");

  // Enabled wake flag keeps the request up
  a_wake_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
    (flags_q[BIT_WAKE] && mask_q[BIT_WAKE] && !wr_flags) |=> irq_o) else $error("wake irq missing");

  // Enabled connect flag keeps the request up
  a_conn_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
    (flags_q[BIT_CONN] && mask_q[BIT_CONN] && !wr_flags) |=> irq_o) else $error("connect irq missing");

  // Enabled done flag keeps the request up
  a_done_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
    (flags_q[BIT_DONE] && mask_q[BIT_DONE] && !wr_flags) |=> irq_o) else $error("done irq missing");

  // All enables clear means no request at all
  a_masked_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    (mask_q == '0) |=> !irq_o) else $error("irq while fully masked");

  // Wake strobe always leaves its flag
  a_wake_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    evt_i.wake |=> flags_q[BIT_WAKE]) else $error("wake flag not set");

  // Done strobe always leaves its flag
  a_done_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    evt_i.done |=> flags_q[BIT_DONE]) else $error("done flag not set");

  // Supply edge flags only on engine 1
  a_supply_edge: assert property (@(posedge mclk_i) disable iff (srst_i)
    $changed(supply_valid_i) |=> flags_q[BIT_SUPPLY] == HOST1) else $error("supply edge flag wrong");

  // ID edge flags only on engine 1
  a_id_edge: assert property (@(posedge mclk_i) disable iff (srst_i)
    $changed(otg_id_i) |=> flags_q[BIT_ID] == HOST1) else $error("id edge flag wrong");

  // Writing zero leaves a pending flag alone
  a_clear_keep: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_flags && !req_i.wdata[BIT_WAKE] && flags_q[BIT_WAKE]) |=> flags_q[BIT_WAKE])
    else $error("flag lost on zero write");

  // New event beats a same-cycle clear
  a_set_wins: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_flags && req_i.wdata[BIT_DONE] && evt_i.done) |=> flags_q[BIT_DONE])
    else $error("clear beat a new event");

  // Every read is answered next cycle
  a_rvalid_pulse: assert property (@(posedge mclk_i) disable iff (srst_i)
    req_i.rd |=> rvalid_o) else $error("read not answered");

  // Idle port shows nothing
  a_rvalid_idle: assert property (@(posedge mclk_i) disable iff (srst_i)
    !req_i.rd |=> (!rvalid_o && rdata_o == '0)) else $error("read port not idle");

  // Flag read carries the live line state
  a_se0_live: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_flags_read |=> rdata_o[BIT_SE0] == $past(line_se0_i)) else $error("se0 state wrong");

  // Reload read returns the programmed value
  a_reload_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_reload_read |=> rdata_o == 16'(reload_q)) else $error("reload read wrong");

  // Frame number still without SOF or reload write
  a_fnum_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!evt_i.sof_sent && !wr_reld) |=> $stable(fnum_q)) else $error("frame number drifted");

  // Ticks never come back to back at 3 of 50
  a_tick_gap: assert property (@(posedge mclk_i) disable iff (srst_i)
    tick |=> !tick) else $error("ticks too close");

  // Nonzero counter steps down by one per tick
  a_count_step: assert property (@(posedge mclk_i) disable iff (srst_i)
    (tick && count_q != '0) |=> count_q == $past(count_q) - 1'b1) else $error("counter step wrong");

  // Reload write lands whole
  a_reload_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_reld |=> reload_q == $past(req_i.wdata[FRAME_W-1:0])) else $error("reload write lost");

endmodule

//--- tb/tb_top.sv
// Purpose: Register-level bench for one host engine (engine 1 map)
// Assumes: One-cycle rd/wr strobes, read data one cycle later
// Notes:   A full frame is too long to wait for; a short first frame is run to expiry instead
`timescale 1ns/1ps
module tb_top;
  import host_sts_pkg::*;
  // ********
  // Stimulus and observation
  // ********
  logic        mclk = 1'b0;       // 200 MHz
  logic        srst = 1'b1;       // Held at start
  reg_req_s    req  = '0;         // Register port request
  bus_evt_s    evt;               // From the peer
  logic        se0, sv, id, irq, frm;
  logic [15:0] rdata, last, cnt_a;
  logic        rvalid;
  int          num_errors = 0;
  int          compares   = 0;
  logic [15:0] ex [4] = '{16'h8000, 16'h8000, 16'h4000, 16'h4000};
  logic        svt [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic        idt [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

  always #2.5 mclk = ~mclk;

  // Short first frame so one expiry fits in the run
  usb_host_status_frame_timer #(.HOST1(1'b1), .FIRST_COUNT(14'h0100)) dut (
    .mclk_i(mclk), .srst_i(srst), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .evt_i(evt), .line_se0_i(se0), .supply_valid_i(sv), .otg_id_i(id),
    .irq_o(irq), .frame_expired_o(frm));
  usb_peer_model peer (
    .mclk_i(mclk), .evt_o(evt), .line_se0_o(se0), .supply_valid_o(sv), .otg_id_o(id));

  // ********
  // Access and compare tasks
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  // Read answer stands one cycle only, so sample it right then
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    chk({15'h0, rvalid}, 16'h0001);
    last = rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    rd(a);
    chk(last, e);
  endtask
  task automatic irqc(input logic e);
    chk({15'h0, irq}, {15'h0, e});
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end

  // ********
  // Scenarios
  // ********
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rdc(HOST1_FRAME_RELOAD_A, 16'h2ee0);
    rdc(HOST1_NEXT_FRAME_A, 16'h0000);
    rdc(HOST1_EVENT_FLAGS_A, 16'h0000);
    rdc(HOST2_EVENT_FLAGS_A, 16'h0000);      // Unmapped here
    wr(HOST1_EVENT_MASK_A, EV_MASK_HOST1);
    rdc(HOST1_EVENT_MASK_A, EV_MASK_HOST1);
    wr(HOST1_EVENT_MASK_A, 16'h0001);
    // Transfer done, then write-one-to-clear
    peer.pulse('{done: 1'b1, wake: 1'b0, sof_sent: 1'b0});
    rdc(HOST1_EVENT_FLAGS_A, 16'h0001);
    irqc(1'b1);
    wr(HOST1_EVENT_FLAGS_A, 16'h0000);
    rdc(HOST1_EVENT_FLAGS_A, 16'h0001);
    wr(HOST1_EVENT_FLAGS_A, 16'h0001);
    rdc(HOST1_EVENT_FLAGS_A, 16'h0000);
    irqc(1'b0);
    // Wakeup masked, then enabled
    peer.pulse('{done: 1'b0, wake: 1'b1, sof_sent: 1'b0});
    rdc(HOST1_EVENT_FLAGS_A, 16'h0040);
    irqc(1'b0);
    wr(HOST1_EVENT_MASK_A, 16'h0040);
    rdc(HOST1_EVENT_MASK_A, 16'h0040);
    irqc(1'b1);
    wr(HOST1_EVENT_FLAGS_A, 16'h0040);
    // Detach and attach
    peer.levels(1'b1, 1'b0, 1'b0);
    rdc(HOST1_EVENT_FLAGS_A, 16'h0014);
    irqc(1'b0);
    wr(HOST1_EVENT_MASK_A, 16'h0010);
    rdc(HOST1_EVENT_MASK_A, 16'h0010);
    irqc(1'b1);
    wr(HOST1_EVENT_FLAGS_A, 16'h0010);
    rdc(HOST1_EVENT_FLAGS_A, 16'h0004);
    peer.levels(1'b0, 1'b0, 1'b0);
    rdc(HOST1_EVENT_FLAGS_A, 16'h0010);
    wr(HOST1_EVENT_FLAGS_A, 16'h0010);
    // Supply and ID, both edge directions
    for (int k = 0; k < 4; k++) begin
      peer.levels(1'b0, svt[k], idt[k]);
      rdc(HOST1_EVENT_FLAGS_A, ex[k]);
      wr(HOST1_EVENT_FLAGS_A, ex[k]);
    end
    // Sampling edges 200 cycles apart: exactly 12 ticks at 3 of 50
    rd(HOST1_FRAME_COUNTDOWN_A);
    cnt_a = last;
    repeat (198) @(posedge mclk);
    rd(HOST1_FRAME_COUNTDOWN_A);
    chk(cnt_a - last, 16'h000c);
    // Frame number and reload
    peer.pulse('{done: 1'b0, wake: 1'b0, sof_sent: 1'b1});
    peer.pulse('{done: 1'b0, wake: 1'b0, sof_sent: 1'b1});
    rdc(HOST1_NEXT_FRAME_A, 16'h0002);
    wr(HOST1_FRAME_RELOAD_A, 16'h0123);
    rdc(HOST1_NEXT_FRAME_A, 16'h0000);
    rdc(HOST1_FRAME_RELOAD_A, 16'h0123);
    // First frame expiry: pulse, flag and enabled request
    wr(HOST1_EVENT_MASK_A, 16'h0200);
    for (int n = 0; n < 6000 && !frm; n++) @(posedge mclk);
    chk({15'h0, frm}, 16'h0001);
    if (frm) begin
      @(posedge mclk);
      chk({15'h0, frm}, 16'h0000);
      rdc(HOST1_EVENT_FLAGS_A, 16'h0200);
      irqc(1'b1);
      wr(HOST1_EVENT_FLAGS_A, 16'h0200);
      rdc(HOST1_EVENT_FLAGS_A, 16'h0000);
      irqc(1'b0);
    end
    wrap_up();
  end
endmodule

//--- tb/usb_peer_model.sv
// Purpose: Behavioural USB peripheral seen from the host port
// Assumes: Called from the bench; changes land just after rising edges
// Notes:   Levels stay put until a scenario moves them
`timescale 1ns/1ps
module usb_peer_model (
  // Clock
  input  wire logic              mclk_i,
  // Toward the host engine
  output host_sts_pkg::bus_evt_s evt_o,
  output logic                   line_se0_o,
  output logic                   supply_valid_o,
  output logic                   otg_id_o
);
  import host_sts_pkg::*;
  // ********
  // Idle: attached, lines in J, no events
  // ********
  initial begin
    evt_o          = '0;
    line_se0_o     = 1'b0;
    supply_valid_o = 1'b0;
    otg_id_o       = 1'b0;
  end
  // One-cycle strobe; never held, so no double counting
  task automatic pulse(input bus_evt_s p);
    @(posedge mclk_i);
    evt_o <= p;
    @(posedge mclk_i);
    evt_o <= '0;
  endtask
  // Line, supply and ID levels
  task automatic levels(input logic se0, input logic sv, input logic id);
    @(posedge mclk_i);
    line_se0_o     <= se0;
    supply_valid_o <= sv;
    otg_id_o       <= id;
    @(posedge mclk_i);
  endtask
endmodule
